// file: bench/cpu_bit_flag_transfer_ops_test.sv
/*
 Self-checking bench for the execution unit with its memory model.
 Assumes the handed-over register map and operation timing.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_bit_flag_transfer_ops_test;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic op_valid_in = 1'b0;
	logic debug_en_in = 1'b0;
	logic debug_resume_in = 1'b0;
	logic bus_wr_in = 1'b0;
	logic bus_rd_in = 1'b0;
	logic [4:0] op_code_in = 5'h00, reg_d_in = 5'h00;
	logic [2:0] bit_sel_in = 3'h0;
	logic [1:0] ptr_sel_in = 2'h0, ptr_mode_in = 2'h0;
	logic [5:0] disp_in = 6'h00, bus_addr_in = 6'h00;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] bus_wdata_in = 8'h00;
	logic busy_out, done_out, dmem_we_out, dmem_re_out, pmem_re_out, wdt_restart_out, debug_halt_out;
	logic [15:0] dmem_addr_out, pmem_addr_out;
	logic [7:0] dmem_wdata_out, dmem_rdata_in, pmem_rdata_in, bus_rdata_out, status_flags_out;
	int fails = 0;
	int total_checks = 0;
	int lat;
	logic [7:0] rd_val, f;
	// Memory side seen in the cycle after an op is taken
	logic c1_re, c1_we, c1_pre, c1_wdt, c1_halt;
	logic [15:0] c1_addr, c1_paddr;
	logic [7:0] c1_wdata;

	cpu_exec_unit cpu_exec_unit_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid_in),
		.op_code_in(op_code_in), .reg_d_in(reg_d_in), .bit_sel_in(bit_sel_in), .ptr_sel_in(ptr_sel_in),
		.ptr_mode_in(ptr_mode_in), .disp_in(disp_in), .addr_in(addr_in), .busy_out(busy_out),
		.done_out(done_out), .dmem_addr_out(dmem_addr_out), .dmem_wdata_out(dmem_wdata_out),
		.dmem_we_out(dmem_we_out), .dmem_re_out(dmem_re_out), .dmem_rdata_in(dmem_rdata_in),
		.pmem_addr_out(pmem_addr_out), .pmem_re_out(pmem_re_out), .pmem_rdata_in(pmem_rdata_in),
		.wdt_restart_out(wdt_restart_out), .debug_en_in(debug_en_in), .debug_resume_in(debug_resume_in),
		.debug_halt_out(debug_halt_out), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
		.bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out),
		.status_flags_out(status_flags_out));
	mem_model mem_model_inst (.clk_in(clk_in), .dmem_addr_in(dmem_addr_out), .dmem_wdata_in(dmem_wdata_out),
		.dmem_we_in(dmem_we_out), .dmem_re_in(dmem_re_out), .dmem_rdata_out(dmem_rdata_in),
		.pmem_addr_in(pmem_addr_out), .pmem_re_in(pmem_re_out), .pmem_rdata_out(pmem_rdata_in));

	// Clock, 10 ns period
	always #5 clk_in = ~clk_in;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_wr_in <= 1'b1;
		bus_addr_in <= a;
		bus_wdata_in <= d;
		@(posedge clk_in);
		bus_wr_in <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		bus_rd_in <= 1'b1;
		bus_addr_in <= a;
		@(posedge clk_in);
		bus_rd_in <= 1'b0;
		#1 check(what, {8'h00, bus_rdata_out}, {8'h00, exp});
	endtask
	// One operation, bounded wait for done, snapshot of the first cycle
	task automatic op(input logic [4:0] c, input logic [4:0] r, input logic [2:0] b, input logic [1:0] p,
			input logic [1:0] m, input logic [15:0] a);
		@(posedge clk_in);
		op_valid_in <= 1'b1;
		op_code_in <= c;
		reg_d_in <= r;
		bit_sel_in <= b;
		ptr_sel_in <= p;
		ptr_mode_in <= m;
		disp_in <= a[5:0];
		addr_in <= a;
		@(posedge clk_in);
		op_valid_in <= 1'b0;
		lat = 0;
		// Done of a one-cycle op stands right after the taking edge
		do begin
			if (lat > 0) begin
				@(posedge clk_in);
			end
			#1 lat++;
			if (lat == 1) begin
				{c1_re, c1_we, c1_pre, c1_wdt, c1_halt} = {dmem_re_out, dmem_we_out, pmem_re_out,
					wdt_restart_out, debug_halt_out};
				{c1_addr, c1_paddr, c1_wdata} = {dmem_addr_out, pmem_addr_out, dmem_wdata_out};
			end
			if (debug_halt_out === 1'b1) begin
				debug_resume_in <= (lat >= 3);
			end
		end while (done_out !== 1'b1 && lat < 40);
		if (done_out !== 1'b1) begin
			fails++;
			close_out();
		end
	endtask

	// Rotate, shift and swap with flag effects
	task automatic t_shift();
		bus_wr(6'h10, 8'h02);
		bus_wr(6'h11, 8'h81);
		bus_wr(6'h12, 8'h3c);
		bus_wr(6'h20, 8'h11);
		op(cpu_exec_pkg::OP_RRC, 5'd16, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("rrc lat", 16'(lat), 16'd1);
		check("rrc flags", {8'h00, status_flags_out}, 16'h001c);
		rchk("rrc res", 6'h10, 8'h81);
		op(cpu_exec_pkg::OP_SRA, 5'd17, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("sra flags", {8'h00, status_flags_out}, 16'h0015);
		rchk("sra res", 6'h11, 8'hc0);
		op(cpu_exec_pkg::OP_SWAP, 5'd18, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("swap flags", {8'h00, status_flags_out}, 16'h0015);
		rchk("swap res", 6'h12, 8'hc3);
	endtask
	// Every flag index set and cleared, others untouched
	task automatic t_flags();
		bus_wr(6'h20, 8'h5a);
		f = 8'h5a;
		for (int i = 0; i < 8; i++) begin
			op(cpu_exec_pkg::OP_FSET, 5'd0, 3'(i), 2'd0, 2'd0, 16'h0000);
			f[i] = 1'b1;
			check("fset", {8'h00, status_flags_out}, {8'h00, f});
			op(cpu_exec_pkg::OP_FCLR, 5'd0, 3'(i), 2'd0, 2'd0, 16'h0000);
			f[i] = 1'b0;
			check("fclr", {8'h00, status_flags_out}, {8'h00, f});
			check("flag lat", 16'(lat), 16'd1);
		end
		bus_wr(6'h3f, 8'hff);
		rchk("unmapped", 6'h3f, 8'h00);
		check("flags kept", {8'h00, status_flags_out}, {8'h00, f});
	endtask
	// Bit transfer both ways, both polarities of the transfer flag
	task automatic t_bits();
		bus_wr(6'h05, 8'h20);
		bus_wr(6'h20, 8'h00);
		op(cpu_exec_pkg::OP_TSTO, 5'd5, 3'd5, 2'd0, 2'd0, 16'h0000);
		check("tstore set", {8'h00, status_flags_out}, 16'h0040);
		check("tstore lat", 16'(lat), 16'd1);
		op(cpu_exec_pkg::OP_TLD, 5'd6, 3'd2, 2'd0, 2'd0, 16'h0000);
		rchk("tload one", 6'h06, 8'h04);
		op(cpu_exec_pkg::OP_TSTO, 5'd5, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("tstore clr", {8'h00, status_flags_out}, 16'h0000);
		op(cpu_exec_pkg::OP_TLD, 5'd6, 3'd2, 2'd0, 2'd0, 16'h0000);
		check("tload lat", 16'(lat), 16'd1);
		rchk("tload zero", 6'h06, 8'h00);
	endtask
	// Loads in each addressing form, pointer carry and borrow
	task automatic t_load();
		bus_wr(6'h20, 8'h2a);
		bus_wr(6'h1a, 8'hff);
		bus_wr(6'h1b, 8'h01);
		bus_wr(6'h1c, 8'h00);
		bus_wr(6'h1d, 8'h02);
		bus_wr(6'h1e, 8'h60);
		op(cpu_exec_pkg::OP_LD, 5'd1, 3'd0, cpu_exec_pkg::PTR_X, cpu_exec_pkg::MODE_INC, 16'h0000);
		check("ld+ lat", 16'(lat), 16'd2);
		check("ld+ addr", c1_re ? c1_addr : 16'hxxxx, 16'h01ff);
		rchk("ld+ data", 6'h01, 8'ha5);
		rchk("ld+ ptr", 6'h1b, 8'h02);
		op(cpu_exec_pkg::OP_LD, 5'd2, 3'd0, cpu_exec_pkg::PTR_Y, cpu_exec_pkg::MODE_DEC, 16'h0000);
		check("ld- addr", c1_re ? c1_addr : 16'hxxxx, 16'h01ff);
		rchk("ld- data", 6'h02, 8'ha5);
		rchk("ld- ptr", 6'h1d, 8'h01);
		op(cpu_exec_pkg::OP_LDQ, 5'd3, 3'd0, cpu_exec_pkg::PTR_Z, cpu_exec_pkg::MODE_PLAIN, 16'h003f);
		check("ldq addr", c1_re ? c1_addr : 16'hxxxx, 16'h009f);
		rchk("ldq data", 6'h03, 8'hc5);
		rchk("ldq ptr", 6'h1e, 8'h60);
		op(cpu_exec_pkg::OP_LDA, 5'd4, 3'd0, 2'd0, 2'd0, 16'h1234);
		check("lda lat", 16'(lat), 16'd2);
		rchk("lda data", 6'h04, 8'h6e);
		check("ld flags", {8'h00, status_flags_out}, 16'h002a);
	endtask
	// Stores in each addressing form
	task automatic t_store();
		bus_wr(6'h09, 8'h99);
		op(cpu_exec_pkg::OP_ST, 5'd9, 3'd0, cpu_exec_pkg::PTR_X, cpu_exec_pkg::MODE_INC, 16'h0000);
		check("st+ addr", c1_we ? c1_addr : 16'hxxxx, 16'h0200);
		check("st+ data", {8'h00, c1_wdata}, 16'h0099);
		rchk("st+ ptr", 6'h1a, 8'h01);
		op(cpu_exec_pkg::OP_ST, 5'd9, 3'd0, cpu_exec_pkg::PTR_Y, cpu_exec_pkg::MODE_DEC, 16'h0000);
		check("st- addr", c1_we ? c1_addr : 16'hxxxx, 16'h01fe);
		op(cpu_exec_pkg::OP_STQ, 5'd9, 3'd0, cpu_exec_pkg::PTR_Z, cpu_exec_pkg::MODE_PLAIN, 16'h0005);
		check("stq addr", c1_we ? c1_addr : 16'hxxxx, 16'h0065);
		op(cpu_exec_pkg::OP_STA, 5'd9, 3'd0, 2'd0, 2'd0, 16'h0abc);
		check("sta addr", c1_we ? c1_addr : 16'hxxxx, 16'h0abc);
		check("sta lat", 16'(lat), 16'd2);
		check("st flags", {8'h00, status_flags_out}, 16'h002a);
	endtask
	// Push then pop round trip, program read, control ops
	task automatic t_misc();
		rchk("sp reset", 6'h21, 8'hff);
		bus_wr(6'h07, 8'h77);
		op(cpu_exec_pkg::OP_PUSH, 5'd7, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("push addr", c1_we ? c1_addr : 16'hxxxx, 16'h00ff);
		rchk("push sp", 6'h21, 8'hfe);
		op(cpu_exec_pkg::OP_POP, 5'd8, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("pop lat", 16'(lat), 16'd2);
		rchk("pop data", 6'h08, 8'h77);
		bus_wr(6'h1e, 8'h10);
		bus_wr(6'h1f, 8'h00);
		op(cpu_exec_pkg::OP_PRD, 5'd0, 3'd0, cpu_exec_pkg::PTR_Z, cpu_exec_pkg::MODE_INC, 16'h0000);
		check("pread lat", 16'(lat), 16'd3);
		check("pread addr", c1_pre ? c1_paddr : 16'hxxxx, 16'h0010);
		rchk("pread data", 6'h00, 8'hb5);
		rchk("pread ptr", 6'h1e, 8'h11);
		bus_wr(6'h20, 8'h33);
		op(cpu_exec_pkg::OP_WDOG, 5'd0, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("wdog", {c1_wdt, 15'(lat)}, 16'h8001);
		op(cpu_exec_pkg::OP_BREAK, 5'd0, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("brk off", {c1_halt, 15'(lat)}, 16'h0001);
		debug_en_in <= 1'b1;
		op(cpu_exec_pkg::OP_BREAK, 5'd0, 3'd0, 2'd0, 2'd0, 16'h0000);
		check("brk on", {c1_halt, 15'(lat >= 4)}, 16'h8001);
		check("ctl flags", {8'h00, status_flags_out}, 16'h0033);
		@(posedge clk_in);
		debug_resume_in <= 1'b0;
		debug_en_in <= 1'b0;
	endtask

	// Reset, then the scenarios, then the verdict
	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		t_shift();
		t_flags();
		t_bits();
		t_load();
		t_store();
		t_misc();
		close_out();
	end
endmodule
`default_nettype wire

// file: bench/mem_model.sv
/*
 Behavioural data and program memory facing the execution unit.
 Assumes registered strobes and addresses from the unit, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	// Clock
	input wire logic clk_in,
	// Data memory
	input wire logic [15:0] dmem_addr_in,
	input wire logic [7:0] dmem_wdata_in,
	input wire logic dmem_we_in,
	input wire logic dmem_re_in,
	output logic [7:0] dmem_rdata_out,
	// Program memory
	input wire logic [15:0] pmem_addr_in,
	input wire logic pmem_re_in,
	output logic [7:0] pmem_rdata_out
);
	logic [7:0] ram [0:65535];
	// Seeded contents, a function of the address
	initial begin
		for (int i = 0; i < 65536; i++) begin
			ram[i] = 8'(i) ^ 8'h5a;
		end
	end
	// Valid only during the strobe, inverted otherwise
	assign dmem_rdata_out = dmem_re_in ? ram[dmem_addr_in] : ~ram[dmem_addr_in];
	// Writes land at the clock edge
	always @(posedge clk_in) begin
		if (dmem_we_in) begin
			ram[dmem_addr_in] <= dmem_wdata_in;
		end
	end
	// Program byte one cycle after the strobe, toggling otherwise
	always @(posedge clk_in) begin
		pmem_rdata_out <= pmem_re_in ? (pmem_addr_in[7:0] ^ 8'ha5) : ~pmem_rdata_out;
	end
endmodule
`default_nettype wire

// file: verilog/cpu_exec_pkg.sv
/*
 Constants, operation codes and state codes shared by the execution unit.
 Assumes a byte-wide data path with 16-bit data and program addresses.
*/
package cpu_exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int REG_NUM = 32;
	// Operation codes handed over by the decoder
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_RRC = 5'h01,
		OP_SRA = 5'h02,
		OP_SWAP = 5'h03,
		OP_FSET = 5'h04,
		OP_FCLR = 5'h05,
		OP_TSTO = 5'h06,
		OP_TLD = 5'h07,
		OP_LD = 5'h08,
		OP_LDQ = 5'h09,
		OP_LDA = 5'h0a,
		OP_ST = 5'h0b,
		OP_STQ = 5'h0c,
		OP_STA = 5'h0d,
		OP_PRD = 5'h0e,
		OP_PUSH = 5'h0f,
		OP_POP = 5'h10,
		OP_WDOG = 5'h11,
		OP_BREAK = 5'h12
	} op_e;
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_MEM = 3'b001,
		S_PWAIT = 3'b010,
		S_PREAD = 3'b011,
		S_HALT = 3'b100
	} state_e;
	// Status flag bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	// Pointer pair select and addressing mode
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;
	localparam logic [4:0] PTR_BASE = 5'h1a;
	localparam logic [1:0] MODE_PLAIN = 2'h0;
	localparam logic [1:0] MODE_INC = 2'h1;
	localparam logic [1:0] MODE_DEC = 2'h2;
	// Register port map
	localparam logic [5:0] ADDR_FLAGS = 6'h20;
	localparam logic [5:0] ADDR_SP_LO = 6'h21;
	localparam logic [5:0] ADDR_SP_HI = 6'h22;
	localparam logic [15:0] SP_DEFAULT = 16'h00ff;
	localparam logic [15:0] SP_FLOOR = 16'h0020;
endpackage

// file: verilog/cpu_exec_unit.sv
/*
 Execution unit for shift, bit transfer, flag, load/store, program read,
 stack and control operations, with its own working registers and flags.
 Assumes a decoder presenting one operation at a time, a data memory with
 combinational read, and a program memory answering one cycle after a read.
*/
// Summary of operation
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Bit store copies a register bit into the transfer flag, one cycle.
// - Bit load writes the transfer flag into a register bit, one cycle.
// - Set or clear any single flag by index, others untouched, one cycle.
// - Post-increment load reads at pointer then bumps pointer, two cycles.
// - Pre-decrement load lowers pointer first, then reads, two cycles.
// - Displaced load reads at pointer plus displacement, two cycles.
// - Post-increment store writes at pointer then bumps it, two cycles.
// - Pre-decrement store lowers pointer then writes there, two cycles.
// - Displaced store writes at pointer plus displacement, two cycles.
// - Direct load fetches byte at instruction address, two cycles.
// - Direct store writes byte at instruction address, two cycles.
// - Program read loads byte at third pointer, optional increment, three cycles.
// - Push stores a register on the stack in two cycles.
// - Pop retrieves the top stack byte in two cycles.
// - Debug halt only when debug is enabled; flags untouched.
// - Watchdog restart pulses the watchdog in one cycle, no flags.
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_unit #(
	parameter logic [15:0] SP_RESET = cpu_exec_pkg::SP_DEFAULT
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Operation request
	input wire logic op_valid_in,
	input wire logic [4:0] op_code_in,
	input wire logic [4:0] reg_d_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic [1:0] ptr_sel_in,
	input wire logic [1:0] ptr_mode_in,
	input wire logic [5:0] disp_in,
	input wire logic [15:0] addr_in,
	output logic busy_out,
	output logic done_out,
	// Data memory
	output logic [15:0] dmem_addr_out,
	output logic [7:0] dmem_wdata_out,
	output logic dmem_we_out,
	output logic dmem_re_out,
	input wire logic [7:0] dmem_rdata_in,
	// Program memory
	output logic [15:0] pmem_addr_out,
	output logic pmem_re_out,
	input wire logic [7:0] pmem_rdata_in,
	// Watchdog and debug
	output logic wdt_restart_out,
	input wire logic debug_en_in,
	input wire logic debug_resume_in,
	output logic debug_halt_out,
	// Register port
	input wire logic [5:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic [7:0] bus_rdata_out,
	// Status
	output logic [7:0] status_flags_out
);
	// Stack must not sit inside the working registers
	if (SP_RESET < cpu_exec_pkg::SP_FLOOR) begin : g_sp_check
		$error("SP_RESET too low");
	end

	logic rst_meta_n;
	logic rst_n;
	logic [7:0] regs [cpu_exec_pkg::REG_NUM];
	logic [7:0] flags;
	logic [15:0] sp;
	cpu_exec_pkg::state_e state;
	logic [4:0] pend_reg;
	logic pend_load;
	logic accept;
	cpu_exec_pkg::op_e op;
	logic [7:0] d_val;
	logic [4:0] pb;
	logic [15:0] ptr_val;
	logic [7:0] next_res;
	logic [7:0] next_flags;
	logic wr_res;
	logic ptr_upd;
	logic [15:0] next_ptr;
	logic [15:0] eff_addr;
	logic is_load;
	logic is_store;
	logic bus_ok;

	// Pointer pair low register index
	function automatic logic [4:0] ptr_base(input logic [1:0] sel);
		ptr_base = cpu_exec_pkg::PTR_BASE + {2'h0, sel, 1'b0};
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// Operand fetch
	assign op = cpu_exec_pkg::op_e'(op_code_in);
	assign accept = op_valid_in && (state == cpu_exec_pkg::S_IDLE);
	assign busy_out = (state != cpu_exec_pkg::S_IDLE);
	assign d_val = regs[reg_d_in];
	assign pb = (op == cpu_exec_pkg::OP_PRD) ? ptr_base(cpu_exec_pkg::PTR_Z) : ptr_base(ptr_sel_in);
	assign ptr_val = {regs[pb + 5'h01], regs[pb]};
	assign status_flags_out = flags;
	assign bus_ok = !busy_out && !op_valid_in;

	// Single-cycle result and flag computation
	always_comb begin
		next_res = d_val;
		next_flags = flags;
		wr_res = 1'b0;
		unique case (op)
			cpu_exec_pkg::OP_RRC: begin
				next_res = {flags[cpu_exec_pkg::FLAG_C], d_val[7:1]};
				wr_res = 1'b1;
			end
			cpu_exec_pkg::OP_SRA: begin
				next_res = {d_val[7], d_val[7:1]};
				wr_res = 1'b1;
			end
			cpu_exec_pkg::OP_SWAP: begin
				next_res = {d_val[3:0], d_val[7:4]};
				wr_res = 1'b1;
			end
			cpu_exec_pkg::OP_FSET: next_flags[bit_sel_in] = 1'b1;
			cpu_exec_pkg::OP_FCLR: next_flags[bit_sel_in] = 1'b0;
			cpu_exec_pkg::OP_TSTO: next_flags[cpu_exec_pkg::FLAG_T] = d_val[bit_sel_in];
			cpu_exec_pkg::OP_TLD: begin
				next_res[bit_sel_in] = flags[cpu_exec_pkg::FLAG_T];
				wr_res = 1'b1;
			end
			default: ;
		endcase
		// Shift flags: carry from bit 0, overflow is negative xor carry
		if (op == cpu_exec_pkg::OP_RRC || op == cpu_exec_pkg::OP_SRA) begin
			next_flags[cpu_exec_pkg::FLAG_C] = d_val[0];
			next_flags[cpu_exec_pkg::FLAG_N] = next_res[7];
			next_flags[cpu_exec_pkg::FLAG_Z] = (next_res == 8'h00);
			next_flags[cpu_exec_pkg::FLAG_V] = next_res[7] ^ d_val[0];
		end
	end

	// Memory address and pointer update
	always_comb begin
		is_load = (op == cpu_exec_pkg::OP_LD) || (op == cpu_exec_pkg::OP_LDQ) ||
			(op == cpu_exec_pkg::OP_LDA) || (op == cpu_exec_pkg::OP_POP);
		is_store = (op == cpu_exec_pkg::OP_ST) || (op == cpu_exec_pkg::OP_STQ) ||
			(op == cpu_exec_pkg::OP_STA) || (op == cpu_exec_pkg::OP_PUSH);
		next_ptr = ptr_val;
		ptr_upd = 1'b0;
		eff_addr = ptr_val;
		unique case (op)
			cpu_exec_pkg::OP_LD, cpu_exec_pkg::OP_ST, cpu_exec_pkg::OP_PRD: begin
				if (ptr_mode_in == cpu_exec_pkg::MODE_INC) begin
					next_ptr = ptr_val + 16'h0001;
					ptr_upd = 1'b1;
				end else if (ptr_mode_in == cpu_exec_pkg::MODE_DEC && op != cpu_exec_pkg::OP_PRD) begin
					next_ptr = ptr_val - 16'h0001;
					eff_addr = next_ptr;
					ptr_upd = 1'b1;
				end
			end
			cpu_exec_pkg::OP_LDQ, cpu_exec_pkg::OP_STQ: eff_addr = ptr_val + {10'h000, disp_in};
			cpu_exec_pkg::OP_LDA, cpu_exec_pkg::OP_STA: eff_addr = addr_in;
			cpu_exec_pkg::OP_PUSH: eff_addr = sp;
			cpu_exec_pkg::OP_POP: eff_addr = sp + 16'h0001;
			default: ;
		endcase
	end

	// Working registers
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cpu_exec_pkg::REG_NUM; i++) begin
				regs[i] <= 8'h00;
			end
		end else begin
			if (accept && wr_res) begin
				regs[reg_d_in] <= next_res;
			end
			if (accept && ptr_upd) begin
				{regs[pb + 5'h01], regs[pb]} <= next_ptr;
			end
			if (state == cpu_exec_pkg::S_MEM && pend_load) begin
				regs[pend_reg] <= dmem_rdata_in;
			end
			if (state == cpu_exec_pkg::S_PREAD) begin
				regs[pend_reg] <= pmem_rdata_in;
			end
			if (bus_wr_in && bus_ok && !bus_addr_in[5]) begin
				regs[bus_addr_in[4:0]] <= bus_wdata_in;
			end
		end
	end

	// Status flags
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			flags <= 8'h00;
		end else if (accept) begin
			flags <= next_flags;
		end else if (bus_wr_in && bus_ok && bus_addr_in == cpu_exec_pkg::ADDR_FLAGS) begin
			flags <= bus_wdata_in;
		end
	end

	// Stack pointer
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sp <= SP_RESET;
		end else if (accept && op == cpu_exec_pkg::OP_PUSH) begin
			sp <= sp - 16'h0001;
		end else if (accept && op == cpu_exec_pkg::OP_POP) begin
			sp <= sp + 16'h0001;
		end else if (bus_wr_in && bus_ok && bus_addr_in == cpu_exec_pkg::ADDR_SP_LO) begin
			sp[7:0] <= bus_wdata_in;
		end else if (bus_wr_in && bus_ok && bus_addr_in == cpu_exec_pkg::ADDR_SP_HI) begin
			sp[15:8] <= bus_wdata_in;
		end
	end

	// Memory ports, driven in the cycle after the request
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dmem_addr_out <= 16'h0000;
			dmem_wdata_out <= 8'h00;
			dmem_we_out <= 1'b0;
			dmem_re_out <= 1'b0;
			pmem_addr_out <= 16'h0000;
			pmem_re_out <= 1'b0;
		end else begin
			dmem_we_out <= accept && is_store;
			dmem_re_out <= accept && is_load;
			pmem_re_out <= accept && op == cpu_exec_pkg::OP_PRD;
			if (accept && (is_load || is_store)) begin
				dmem_addr_out <= eff_addr;
				dmem_wdata_out <= d_val;
			end
			if (accept && op == cpu_exec_pkg::OP_PRD) begin
				pmem_addr_out <= ptr_val;
			end
		end
	end

	// Sequencer
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= cpu_exec_pkg::S_IDLE;
			pend_reg <= 5'h00;
			pend_load <= 1'b0;
			done_out <= 1'b0;
			wdt_restart_out <= 1'b0;
			debug_halt_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			wdt_restart_out <= 1'b0;
			unique case (state)
				cpu_exec_pkg::S_IDLE: begin
					if (accept) begin
						pend_reg <= reg_d_in;
						pend_load <= is_load;
						wdt_restart_out <= (op == cpu_exec_pkg::OP_WDOG);
						if (is_load || is_store) begin
							state <= cpu_exec_pkg::S_MEM;
						end else if (op == cpu_exec_pkg::OP_PRD) begin
							state <= cpu_exec_pkg::S_PWAIT;
						end else if (op == cpu_exec_pkg::OP_BREAK && debug_en_in) begin
							state <= cpu_exec_pkg::S_HALT;
							debug_halt_out <= 1'b1;
						end else begin
							done_out <= 1'b1;
						end
					end
				end
				cpu_exec_pkg::S_MEM: begin
					state <= cpu_exec_pkg::S_IDLE;
					done_out <= 1'b1;
				end
				cpu_exec_pkg::S_PWAIT: state <= cpu_exec_pkg::S_PREAD;
				cpu_exec_pkg::S_PREAD: begin
					state <= cpu_exec_pkg::S_IDLE;
					done_out <= 1'b1;
				end
				cpu_exec_pkg::S_HALT: begin
					if (debug_resume_in) begin
						state <= cpu_exec_pkg::S_IDLE;
						debug_halt_out <= 1'b0;
						done_out <= 1'b1;
					end
				end
				default: state <= cpu_exec_pkg::S_IDLE;
			endcase
		end
	end

	// Register port read, data only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata_out <= 8'h00;
		end else if (!bus_rd_in) begin
			bus_rdata_out <= 8'h00;
		end else if (!bus_addr_in[5]) begin
			bus_rdata_out <= regs[bus_addr_in[4:0]];
		end else if (bus_addr_in == cpu_exec_pkg::ADDR_FLAGS) begin
			bus_rdata_out <= flags;
		end else if (bus_addr_in == cpu_exec_pkg::ADDR_SP_LO) begin
			bus_rdata_out <= sp[7:0];
		end else if (bus_addr_in == cpu_exec_pkg::ADDR_SP_HI) begin
			bus_rdata_out <= sp[15:8];
		end else begin
			bus_rdata_out <= 8'h00;
		end
	end

	// Checks
	a_rotate_value: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_RRC |=> done_out &&
		regs[$past(reg_d_in)] == {$past(flags[0]), $past(d_val[7:1])} && flags[0] == $past(d_val[0]))
		else $error("rotate result wrong");
	a_shift_value: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_SRA |=>
		regs[$past(reg_d_in)] == {$past(d_val[7]), $past(d_val[7:1])} && flags[0] == $past(d_val[0]))
		else $error("shift result wrong");
	a_swap_value: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_SWAP |=>
		regs[$past(reg_d_in)] == {$past(d_val[3:0]), $past(d_val[7:4])} && flags == $past(flags))
		else $error("swap wrong");
	a_tstore_flag: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_TSTO |=> flags[6] == $past(d_val[bit_sel_in]) &&
		flags[5:0] == $past(flags[5:0]) && flags[7] == $past(flags[7]) && done_out)
		else $error("bit store wrong");
	a_tload_keep: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_TLD |=> flags == $past(flags) &&
		regs[$past(reg_d_in)][$past(bit_sel_in)] == $past(flags[6]))
		else $error("bit load wrong");
	a_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_FSET |=> flags == ($past(flags) | (8'h01 << $past(bit_sel_in))))
		else $error("flag set wrong");
	a_load_two: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && is_load |=> dmem_re_out && !done_out ##1 done_out && !busy_out)
		else $error("load timing wrong");
	a_predec_addr: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_LD && ptr_mode_in == cpu_exec_pkg::MODE_DEC
		|=> dmem_addr_out == $past(ptr_val) - 16'h0001)
		else $error("pre-decrement address wrong");
	a_store_two: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && is_store |=> dmem_we_out && flags == $past(flags) ##1 done_out && !dmem_we_out)
		else $error("store timing wrong");
	a_pread_three: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_PRD |=> pmem_re_out ##1 !done_out ##1 done_out)
		else $error("program read timing wrong");
	a_push_addr: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_PUSH |=> dmem_we_out && dmem_addr_out == $past(sp) &&
		sp == $past(sp) - 16'h0001)
		else $error("push wrong");
	a_wdog_pulse: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_WDOG |=> wdt_restart_out && done_out ##1 !wdt_restart_out)
		else $error("watchdog pulse wrong");
	a_halt_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
		accept && op == cpu_exec_pkg::OP_BREAK |=> debug_halt_out == $past(debug_en_in) &&
		flags == $past(flags))
		else $error("debug halt wrong");
endmodule
`default_nettype wire
